// [cc_timer_regs.vh]
// What this block does
// R01 - Counter equal to periodic compare sets match flag; enabled bit 0x0001 raises interrupt.
// R02 - Writing one to a clear bit clears that channel's capture or compare flag.
// R03 - Software adds a fixed increment to the compare register on each match.
// R04 - Prescaler divides the peripheral clock by its setting plus one.
// R05 - Counter start register holds one run bit per sub-block.
// R06 - Global timer enable gates counting; 0x09 enables prescaler and this timer.
// R07 - With io control 0xBBB5, trigger rising edge copies counter into capture register.
// R08 - Capture with enable bit 0x0001 set raises the capture interrupt.
// R09 - One-shot channel goes active when counter matches its start register.
// R10 - One-shot channel goes inactive when counter matches its end register.
// R11 - Software loads start and end registers from captured value plus offsets.
// R12 - Each channel has own offset and width; active level selectable.
// R13 - Forced compare via control 0x00E3 drives one-shot outputs inactive.
// R14 - Control 0x00E3 disables clearing mode and selects clock bus 3 for sub-block 2.
// R15 - Software offset should exceed the pulse-setting routine time of about 3.3 us.
// R16 - Pulse width at least one prescaler cycle; values below cycle times counter max. Here start equal to end gives no pulse: the end match wins.
// R17 - Io control 0x0003 enables sub-block 0 compare and toggle output on match.
// R18 - Level-switching variant: handler alternately writes port output zero and one.
// R19 - Clearing mode: match with periodic compare resets counter to zero.
// R20 - Without clearing mode the counter runs freely and wraps to zero.
`ifndef CC_TIMER_REGS_VH
`define CC_TIMER_REGS_VH
`define GTE_PRESC_BIT   0
`define GTE_TIMER_BIT   3
`define RUN_SB0_BIT     0
`define RUN_SB2_BIT     2
`define IRQ_EN_BIT      0
`define CLR_CH0_BIT     0
`define CLR_CH1_BIT     1
`define CLR_CH2_BIT     2
`define CLR_CH3_BIT     3
`define IOC0_CMP_EN     16'h0003
`define IOC2_CAP_OS     16'h0005
`define IOC2_OS_MASK    16'hFFF0
`define IOC2_OS_LOW     16'hBBB0
`define IOC2_OS_HIGH    16'hAAA0
`define IOC2_CH0_MASK   16'h000F
`define CTL_CLKSEL_MASK 16'h0007
`define CTL_CLKBUS3     16'h0003
`define CTL_PERIODIC    16'h0008
`define CTL_FORCE_LSB   5
`define CTL_FORCE_W     3
`define CTL_FORCE_ALL   3'h7
`define PRESC_W         16
`define CNT_MAX         28'hFFFFFFF
`endif

// [compare_capture_pulse_timer.v]
`timescale 1ns/1ns
`include "cc_timer_regs.vh"
module compare_capture_pulse_timer #(
  parameter CW = 28,
  parameter NCH = 3
) (
  // Clock and reset
  input  wire              clock,
  input  wire              rst_n,
  // Global control
  input  wire [7:0]        global_timer_enable,
  input  wire [15:0]       prescaler_div_0,
  input  wire [15:0]       prescaler_div_3,
  input  wire [7:0]        counter_start_reg,
  // Sub-block 0
  input  wire [15:0]       io_control_sb0,
  input  wire [15:0]       irq_enable_sb0,
  input  wire [15:0]       flag_clear_sb0,
  input  wire [CW-1:0]     periodic_compare_reg,
  input  wire              periodic_clear_en,
  // Sub-block 2
  input  wire [15:0]       io_control_sb2,
  input  wire [15:0]       irq_enable_sb2,
  input  wire [15:0]       flag_clear_sb2,
  input  wire [15:0]       subblock_control,
  input  wire              subblock_control_wr,
  input  wire [NCH*CW-1:0] oneshot_start_reg,
  input  wire [NCH*CW-1:0] oneshot_end_reg,
  // Pins
  input  wire              capture_trigger_pin,
  // Status and results
  output reg  [CW-1:0]     counter_sb0_q,
  output reg  [CW-1:0]     subblock_counter_q,
  output reg  [CW-1:0]     capture_value_reg_q,
  output wire [15:0]       flag_status,
  output reg  [3:0]        flag_status_sb2_q,
  output wire              compare_irq,
  output wire              capture_irq,
  output reg               compare_out_q,
  output reg  [NCH-1:0]    oneshot_out_q
);

  function [CW-1:0] inc_wrap;
    input [CW-1:0] v;
    begin
      inc_wrap = (v == `CNT_MAX) ? {CW{1'b0}} : v + {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Reset release
  reg rst_s1_q;
  reg rst_s2_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_i_n = rst_s2_q;

  // Trigger pin synchroniser
  reg trig_s1_q;
  reg trig_s2_q;
  reg trig_s3_q;
  always @(posedge clock or negedge rst_i_n) begin
    if (!rst_i_n) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= capture_trigger_pin;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end
  wire trig_rise = trig_s2_q & ~trig_s3_q;

  // Prescalers
  wire presc_en = global_timer_enable[`GTE_PRESC_BIT];                         // R06
  wire tmr_en   = global_timer_enable[`GTE_TIMER_BIT] & presc_en;              // R06
  reg  [`PRESC_W-1:0] psc0_q;
  reg  [`PRESC_W-1:0] psc3_q;
  wire tick0 = presc_en & (psc0_q == prescaler_div_0);                         // R04
  wire tick3 = presc_en & (psc3_q == prescaler_div_3);                         // R04
  always @(posedge clock or negedge rst_i_n) begin
    if (!rst_i_n) begin
      psc0_q <= {`PRESC_W{1'b0}};
      psc3_q <= {`PRESC_W{1'b0}};
    end else if (!presc_en) begin
      psc0_q <= {`PRESC_W{1'b0}};
      psc3_q <= {`PRESC_W{1'b0}};
    end else begin
      psc0_q <= tick0 ? {`PRESC_W{1'b0}} : psc0_q + 16'h0001;                 // R04
      psc3_q <= tick3 ? {`PRESC_W{1'b0}} : psc3_q + 16'h0001;                 // R04
    end
  end

  // Sub-block 0: periodic compare
  wire run0     = tmr_en & counter_start_reg[`RUN_SB0_BIT] & tick0;            // R05
  wire cmp0_en  = (io_control_sb0 == `IOC0_CMP_EN);                            // R17
  wire match0   = run0 & cmp0_en & (counter_sb0_q == periodic_compare_reg);    // R01
  reg  flag0_q;
  always @(posedge clock or negedge rst_i_n) begin
    if (!rst_i_n) begin
      counter_sb0_q <= {CW{1'b0}};
      flag0_q       <= 1'b0;
      compare_out_q <= 1'b0;
    end else begin
      if (run0) begin
        if (match0 && periodic_clear_en)
          counter_sb0_q <= {CW{1'b0}};                                         // R19
        else
          counter_sb0_q <= inc_wrap(counter_sb0_q);                            // R20
      end
      if (match0)
        flag0_q <= 1'b1;                                                       // R01
      else if (flag_clear_sb0[`CLR_CH0_BIT])
        flag0_q <= 1'b0;                                                       // R02
      if (match0)
        compare_out_q <= ~compare_out_q;                                       // R17
    end
  end
  assign flag_status = {15'h0000, flag0_q};
  assign compare_irq = flag0_q & irq_enable_sb0[`IRQ_EN_BIT];                  // R01

  // Sub-block 2: capture and one-shot
  reg [15:0] ctl_q;
  always @(posedge clock or negedge rst_i_n) begin
    if (!rst_i_n)
      ctl_q <= 16'h0000;
    else if (subblock_control_wr)
      ctl_q <= subblock_control;                                               // R14
  end
  wire sb2_tick   = ((ctl_q & `CTL_CLKSEL_MASK) == `CTL_CLKBUS3) ? tick3 : tick0; // R14
  wire run2       = tmr_en & counter_start_reg[`RUN_SB2_BIT] & sb2_tick;       // R05
  wire cap_en     = ((io_control_sb2 & `IOC2_CH0_MASK) == `IOC2_CAP_OS);       // R07
  wire os_low     = ((io_control_sb2 & `IOC2_OS_MASK) == `IOC2_OS_LOW);        // R12
  wire os_high    = ((io_control_sb2 & `IOC2_OS_MASK) == `IOC2_OS_HIGH);       // R12
  wire os_en      = os_low | os_high;
  wire act_lvl    = os_high;                                                   // R12
  wire capture    = cap_en & trig_rise;                                        // R07
  wire [NCH-1:0] force_end = subblock_control_wr ?
                  subblock_control[`CTL_FORCE_LSB +: `CTL_FORCE_W] : {NCH{1'b0}}; // R13
  wire [NCH-1:0] clr_bits  = flag_clear_sb2[`CLR_CH3_BIT:`CLR_CH1_BIT];

  reg  [NCH-1:0] start_hit;
  reg  [NCH-1:0] end_hit;
  integer i;
  always @* begin
    start_hit = {NCH{1'b0}};
    end_hit   = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1) begin
      start_hit[i] = run2 & os_en & (subblock_counter_q == oneshot_start_reg[i*CW +: CW]); // R09
      end_hit[i]   = run2 & os_en & (subblock_counter_q == oneshot_end_reg[i*CW +: CW]);   // R10
    end
  end

  integer k;
  always @(posedge clock or negedge rst_i_n) begin
    if (!rst_i_n) begin
      subblock_counter_q  <= {CW{1'b0}};
      capture_value_reg_q <= {CW{1'b0}};
      flag_status_sb2_q   <= 4'h0;
      oneshot_out_q       <= {NCH{1'b0}};
    end else begin
      if (run2)
        subblock_counter_q <= inc_wrap(subblock_counter_q);                    // R20
      if (capture)
        capture_value_reg_q <= subblock_counter_q;                             // R07
      if (capture)
        flag_status_sb2_q[`CLR_CH0_BIT] <= 1'b1;                               // R08
      else if (flag_clear_sb2[`CLR_CH0_BIT])
        flag_status_sb2_q[`CLR_CH0_BIT] <= 1'b0;                               // R02
      for (k = 0; k < NCH; k = k + 1) begin
        if (end_hit[k] | start_hit[k])
          flag_status_sb2_q[k+1] <= 1'b1;
        else if (clr_bits[k])
          flag_status_sb2_q[k+1] <= 1'b0;                                      // R02
        if (force_end[k] | end_hit[k])
          oneshot_out_q[k] <= ~act_lvl;                                        // R13 R10 R16
        else if (start_hit[k])
          oneshot_out_q[k] <= act_lvl;                                         // R09
        else if (!os_en)
          oneshot_out_q[k] <= 1'b0;
      end
    end
  end
  assign capture_irq = flag_status_sb2_q[`CLR_CH0_BIT] & irq_enable_sb2[`IRQ_EN_BIT]; // R08

endmodule // compare_capture_pulse_timer

// [cc_timer_sva.sv]
`timescale 1ns/1ns
module cc_timer_sva #(parameter CW = 28) (
  // Watched ports
  input wire logic            clock, rst_n, periodic_clear_en, subblock_control_wr, capture_trigger_pin, compare_irq,
  input wire logic [15:0]     io_control_sb0, irq_enable_sb0, flag_clear_sb0, io_control_sb2, subblock_control, flag_status,
  input wire logic [CW-1:0]   periodic_compare_reg, counter_sb0_q, subblock_counter_q,
  input wire logic [3*CW-1:0] oneshot_start_reg, oneshot_end_reg,
  input wire logic [3:0]      flag_status_sb2_q,
  input wire logic [2:0]      oneshot_out_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire m0 = counter_sb0_q == periodic_compare_reg && io_control_sb0 == 16'h0003;
  wire os = io_control_sb2[15:4] == 12'hBBB && !subblock_control_wr;
  wire st = subblock_counter_q == oneshot_start_reg[CW-1:0];
  wire en = subblock_counter_q == oneshot_end_reg[CW-1:0];
  a_cmp_flag_set: assert property ($changed(counter_sb0_q) && $past(m0) |-> flag_status[0])
    else $error("compare flag not set");
  a_cmp_irq_lvl: assert property (compare_irq == (flag_status[0] & irq_enable_sb0[0]))
    else $error("compare irq wrong");
  a_flag_clr: assert property (flag_clear_sb0[0] && !m0 |=> !flag_status[0])
    else $error("flag not cleared");
  a_per_clear: assert property ($changed(counter_sb0_q) && $past(m0 && periodic_clear_en) |-> counter_sb0_q == 0)
    else $error("counter not cleared");
  a_free_step: assert property ($changed(counter_sb0_q) && !$past(periodic_clear_en)
    |-> counter_sb0_q - $past(counter_sb0_q) == CW'(1)) else $error("counter step wrong");
  a_cap_flag: assert property ($rose(capture_trigger_pin) && io_control_sb2[3:0] == 4'h5 |-> ##[1:4] flag_status_sb2_q[0])
    else $error("capture flag late");
  a_os_start: assert property ($changed(subblock_counter_q) && $past(os && st && !en) |-> !oneshot_out_q[0])
    else $error("pulse start missed");
  a_os_end: assert property ($changed(subblock_counter_q) && $past(os && en && !st) |-> oneshot_out_q[0])
    else $error("pulse end missed");
  a_force_end: assert property (subblock_control_wr && subblock_control[7:5] == 3'h7 && io_control_sb2[15:4] == 12'hBBB
    |=> oneshot_out_q == 3'h7) else $error("force end failed");
endmodule // cc_timer_sva
bind compare_capture_pulse_timer cc_timer_sva #(.CW(CW)) u_sva (.*);

// [trigger_source.sv]
`timescale 1ns/1ns
module trigger_source (
  // Clock
  input wire logic clock,
  // Trigger pin
  output logic     pin
);
  initial pin = 1'b0;
  // Rising edge, held high for len cycles
  task pulse(input int len);
    @(posedge clock);
    #1 pin = 1'b1;
    repeat (len) @(posedge clock);
    #1 pin = 1'b0;
  endtask
endmodule // trigger_source

// [testbench.sv]
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; $display("mismatch %s exp %0h got %0h", n, e, a); end end
module testbench;
  logic        clock = 0, rst_n = 0, periodic_clear_en = 0, subblock_control_wr = 0, compare_irq, capture_irq, compare_out_q;
  logic [7:0]  global_timer_enable = 8'h09, counter_start_reg = 8'h05;
  logic [15:0] prescaler_div_0 = 16'h0000, prescaler_div_3 = 16'h0003, io_control_sb0 = 16'h0003, flag_status;
  logic [15:0] irq_enable_sb0 = 16'h0001, flag_clear_sb0 = 16'h0000, io_control_sb2 = 16'hBBB5, subblock_control = 16'h00E3;
  logic [15:0] irq_enable_sb2 = 16'h0001, flag_clear_sb2 = 16'h0000;
  logic [27:0] periodic_compare_reg = 28'h0000050, counter_sb0_q, subblock_counter_q, capture_value_reg_q, cap;
  logic [83:0] oneshot_start_reg = {3{28'hFFFFFFF}}, oneshot_end_reg = '0;
  logic [3:0]  flag_status_sb2_q;
  logic [2:0]  oneshot_out_q, o, exp [5] = '{3'h6, 3'h4, 3'h1, 3'h3, 3'h7};
  logic        gp_port_output = 1'b0;
  wire         capture_trigger_pin;
  int          err_total = 0, checks_done = 0, n;
  compare_capture_pulse_timer dut (.*);
  trigger_source u_trig (.clock(clock), .pin(capture_trigger_pin));
  always #5 clock = ~clock;
  task tick; @(posedge clock); #1; endtask
  task wf; n = 0; while (flag_status[0] !== 1'b1 && n < 300) begin tick; n++; end endtask
  task clr0; flag_clear_sb0 = 16'h0001; tick; flag_clear_sb0 = 16'h0000; endtask
  task gap(input bit s, input int e);
    repeat (2) begin cap = s ? subblock_counter_q : counter_sb0_q; n = 0;
      while ((s ? subblock_counter_q : counter_sb0_q) === cap && n < 50) begin tick; n++; end end
    `CHK("gap", e, n)
  endtask
  task still; tick; tick; cap = counter_sb0_q; repeat (25) tick; `CHK("still", cap, counter_sb0_q) endtask
  task t_sb0;
    wf; `CHK("cnt", 28'h0000051, counter_sb0_q)
    gp_port_output = ~gp_port_output; `CHK("port", gp_port_output, compare_out_q)
    `CHK("irq", 1'b1, compare_irq)
    `CHK("tog", 1'b1, compare_out_q)
    periodic_compare_reg = periodic_compare_reg + 28'h0000050;
    clr0; `CHK("flag", 1'b0, flag_status[0])
    wf; `CHK("cnt", 28'h00000A1, counter_sb0_q)
    gp_port_output = ~gp_port_output; `CHK("port", gp_port_output, compare_out_q)
    `CHK("tog", 1'b0, compare_out_q)
    periodic_clear_en = 1'b1;
    periodic_compare_reg = 28'h00000C0;
    clr0; wf; `CHK("cnt", 28'h0000000, counter_sb0_q)
  endtask
  task t_gate;
    prescaler_div_0 = 16'h0009;
    gap(0, 10);
    global_timer_enable = 8'h00; still;
    global_timer_enable = 8'h09; counter_start_reg = 8'h04; still;
    counter_start_reg = 8'h05;
  endtask
  task t_os;
    subblock_control_wr = 1'b1; tick; subblock_control_wr = 1'b0;
    `CHK("force", 3'h7, oneshot_out_q)
    gap(1, 4);
    u_trig.pulse(3);
    n = 0; while (flag_status_sb2_q[0] !== 1'b1 && n < 20) begin tick; n++; end
    `CHK("cirq", 1'b1, capture_irq)
    cap = capture_value_reg_q; `CHK("cap", 1'b1, subblock_counter_q - cap <= 28'h2)
    for (int i = 0; i < 3; i++) begin
      oneshot_start_reg[i*28+:28] = cap + 28'h64 * (i + 1);
      oneshot_end_reg[i*28+:28] = cap + 28'h64 * (i + 1) + 28'hC8; end
    flag_clear_sb2 = 16'h0001; tick; flag_clear_sb2 = 16'h0000; `CHK("cirq", 1'b0, capture_irq)
    for (int i = 0; i < 5; i++) begin o = oneshot_out_q; n = 0;
      while (oneshot_out_q === o && n < 600) begin tick; n++; end
      `CHK("out", exp[i], oneshot_out_q) end
    `CHK("chflg", 3'h7, flag_status_sb2_q[3:1])
    flag_clear_sb2 = 16'h000E; tick; flag_clear_sb2 = 16'h0000; `CHK("chflg", 3'h0, flag_status_sb2_q[3:1])
  endtask
  task give_verdict;
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin repeat (8) @(posedge clock); #1 rst_n = 1'b1; repeat (3) tick; t_sb0; t_gate; t_os; give_verdict; end
  initial begin #300000; err_total++; give_verdict; end
endmodule // testbench
